// ==== rtl/clk_sleep_pkg.sv ====
`default_nettype none
package clk_sleep_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_PRESCALE = 4'h0;
	localparam logic [3:0] ADDR_LOW_POWER = 4'h1;
	localparam logic [3:0] ADDR_SLEEP_STATUS = 4'h2;
	localparam int UNLOCK_BIT = 7;
	localparam int HALT_ARM_BIT = 0;
	localparam int MODE_LSB = 1;
	localparam int MODE_MSB = 3;
	localparam logic [3:0] CODE_FAST = 4'h0;
	localparam logic [3:0] CODE_SLOW = 4'h3;
	localparam logic [3:0] CODE_MAX = 4'h8;
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
	localparam logic [2:0] WAKE_EXTRA_CYCLES = 3'h4;
	localparam logic [7:0] LOW_POWER_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Modes and states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_IDLE = 3'h0,
		MODE_ADC_QUIET = 3'h1,
		MODE_POWER_DOWN = 3'h2,
		MODE_POWER_SAVE = 3'h3,
		MODE_STANDBY = 3'h6
	} power_mode_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_SLEEP = 2'h1,
		ST_WAKE = 2'h3
	} sleep_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic clk_cpu_en;
		logic clk_io_en;
		logic clk_adc_en;
		logic clk_async_en;
		logic osc_run;
	} clk_gate_t;

endpackage
`default_nettype wire

// ==== rtl/clock_prescaler_sleep_ctrl.sv ====
// The strobed register port and the register addresses are this design's own decisions.
`default_nettype none

// What this block does
// - New division takes effect within two edges
// - Unlock bit updates only with others zero
// - Unlock clears after four cycles or code
// - Rewriting unlock neither restarts nor clears
// - Division is two to the code power
// - Divided clock enables all synchronous logic
// - Reset code set by the slow fuse
// - Codes 0 to 8 writable regardless of fuse; higher codes clamp to 8
// - Sleep only when armed at sleep instruction
// - Mode code selects the sleep mode
// - Wake on interrupt, halt four extra cycles
// - Register contents kept across sleep
// - Reset during sleep restarts from vector
// - Switching gives no glitch, but may cut the tick period in progress short
// - Power-down stops all generated clocks except sys_clk_en, which keeps ticking
module clock_prescaler_sleep_ctrl #(
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic initial_slow_fuse,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic sleep_instr,
	input wire logic wake_irq,
	input wire logic osc_ready,
	output logic sys_clk_en,
	output logic cpu_halt,
	output logic clk_cpu_en,
	output logic clk_io_en,
	output logic clk_adc_en,
	output logic clk_async_en,
	output logic osc_run,
	output logic wake_done
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef clk_sleep_pkg::sleep_state_t clock_sleep_state_t;

	typedef struct packed {
		logic [3:0] division_code;
		logic prescale_change_unlock;
		logic [2:0] unlock_cnt;
		logic halt_arm;
		logic [2:0] power_state_code;
		clock_sleep_state_t st;
		logic [2:0] mode;
		logic [2:0] wake_cnt;
		logic [CNT_W-1:0] div_cnt;
		logic tick;
		logic [7:0] rdata;
		logic fuse_done;
		logic wake_done;
	} state_t;

	state_t cur_ff;
	state_t nxt_s;
	clk_sleep_pkg::reg_req_t req;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// One compare for each write strobe; reads decode the same map in the read port case.
	function automatic logic reg_hit(input logic [3:0] a,
		input logic [3:0] target);
		reg_hit = (a == target);
	endfunction

	// Reserved division codes fall back to the slowest legal ratio.
	function automatic logic [3:0] clamp_code(input logic [3:0] c);
		if (c <= clk_sleep_pkg::CODE_MAX) begin
			clamp_code = c;
		end else begin
			clamp_code = clk_sleep_pkg::CODE_MAX;
		end
	endfunction

	function automatic logic [CNT_W-1:0] ratio_mask(input logic [3:0] c);
		logic [CNT_W:0] one;
		one = {{CNT_W{1'b0}}, 1'b1};
		ratio_mask = CNT_W'((one << c) - one);
	endfunction

	function automatic logic mode_ok(input logic [2:0] m);
		mode_ok = (m == clk_sleep_pkg::MODE_IDLE) ||
			(m == clk_sleep_pkg::MODE_ADC_QUIET) ||
			(m == clk_sleep_pkg::MODE_POWER_DOWN) ||
			(m == clk_sleep_pkg::MODE_POWER_SAVE) ||
			(m == clk_sleep_pkg::MODE_STANDBY);
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic others_zero;
		logic wr_pre;
		logic wr_lp;
		logic [3:0] code_in;
		others_zero = 1'b0;
		wr_pre = 1'b0;
		wr_lp = 1'b0;
		code_in = 4'h0;
		nxt_s = cur_ff;
		nxt_s.wake_done = 1'b0;
		wr_pre = req.wr &&
			reg_hit(req.addr, clk_sleep_pkg::ADDR_PRESCALE);
		wr_lp = req.wr &&
			reg_hit(req.addr, clk_sleep_pkg::ADDR_LOW_POWER);
		others_zero = (req.wdata[6:0] == 7'h00);
		code_in = req.wdata[3:0];

		// ------------------------------------------------------------
		// Fuse load
		// ------------------------------------------------------------
		// The fuse is sampled after reset release; a strap may not feed
		// an asynchronously reset flop directly.
		if (!cur_ff.fuse_done) begin
			nxt_s.fuse_done = 1'b1;
			nxt_s.division_code = initial_slow_fuse ?
				clk_sleep_pkg::CODE_SLOW : clk_sleep_pkg::CODE_FAST;
			nxt_s.div_cnt = '0;
		end

		// ------------------------------------------------------------
		// Unlock window
		// ------------------------------------------------------------
		// Unlock timeout runs from the first set only.
		if (cur_ff.prescale_change_unlock) begin
			if (cur_ff.unlock_cnt == clk_sleep_pkg::UNLOCK_CYCLES - 3'h1) begin
				nxt_s.prescale_change_unlock = 1'b0;
			end else begin
				nxt_s.unlock_cnt = cur_ff.unlock_cnt + 3'h1;
			end
		end

		// ------------------------------------------------------------
		// Prescale writes
		// ------------------------------------------------------------
		if (wr_pre && cur_ff.fuse_done) begin
			if (req.wdata[clk_sleep_pkg::UNLOCK_BIT] && others_zero) begin
				if (!cur_ff.prescale_change_unlock) begin
					nxt_s.prescale_change_unlock = 1'b1;
					nxt_s.unlock_cnt = 3'h0;
				end
				// A rewrite keeps the running window as it is.
			end else if (!req.wdata[clk_sleep_pkg::UNLOCK_BIT]) begin
				if (cur_ff.prescale_change_unlock) begin
					// Reserved codes are held at the largest ratio.
					nxt_s.division_code = clamp_code(code_in);
					nxt_s.prescale_change_unlock = 1'b0;
				end
				// Without an open window the write is dropped.
			end
		end

		// ------------------------------------------------------------
		// Divider
		// ------------------------------------------------------------
		// Divider: the new ratio mask applies from the next compare, so the
		// period in progress may end early while the ratio changes.
		nxt_s.tick = 1'b0;
		if ((cur_ff.div_cnt & ratio_mask(cur_ff.division_code)) ==
			ratio_mask(cur_ff.division_code)) begin
			nxt_s.div_cnt = '0;
			nxt_s.tick = 1'b1;
		end else begin
			nxt_s.div_cnt = cur_ff.div_cnt + CNT_W'(1);
		end
		if (!cur_ff.fuse_done) begin
			nxt_s.div_cnt = '0;
			nxt_s.tick = 1'b0;
		end

		// ------------------------------------------------------------
		// Low power register
		// ------------------------------------------------------------
		if (wr_lp) begin
			nxt_s.halt_arm = req.wdata[clk_sleep_pkg::HALT_ARM_BIT];
			nxt_s.power_state_code =
				req.wdata[clk_sleep_pkg::MODE_MSB:clk_sleep_pkg::MODE_LSB];
		end

		// ------------------------------------------------------------
		// Sleep machine
		// ------------------------------------------------------------
		unique case (cur_ff.st)
			clk_sleep_pkg::ST_RUN: begin
				if (sleep_instr && cur_ff.halt_arm &&
					mode_ok(cur_ff.power_state_code)) begin
					nxt_s.st = clk_sleep_pkg::ST_SLEEP;
					nxt_s.mode = cur_ff.power_state_code;
				end
				// Unarmed or reserved code: nothing happens.
			end
			clk_sleep_pkg::ST_SLEEP: begin
				if (wake_irq) begin
					nxt_s.st = clk_sleep_pkg::ST_WAKE;
					nxt_s.wake_cnt = 3'h0;
				end
			end
			clk_sleep_pkg::ST_WAKE: begin
				if (osc_ready) begin
					if (cur_ff.wake_cnt ==
						clk_sleep_pkg::WAKE_EXTRA_CYCLES - 3'h1) begin
						nxt_s.st = clk_sleep_pkg::ST_RUN;
						nxt_s.wake_done = 1'b1;
					end else begin
						nxt_s.wake_cnt = cur_ff.wake_cnt + 3'h1;
					end
				end
			end
			default: begin
				nxt_s.st = clk_sleep_pkg::ST_RUN;
			end
		endcase

		// ------------------------------------------------------------
		// Read port
		// ------------------------------------------------------------
		// Read data stand for one cycle only; an idle port reads as zero.
		nxt_s.rdata = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				clk_sleep_pkg::ADDR_PRESCALE: begin
					nxt_s.rdata = {cur_ff.prescale_change_unlock, 3'h0,
						cur_ff.division_code};
				end
				clk_sleep_pkg::ADDR_LOW_POWER: begin
					nxt_s.rdata = {4'h0, cur_ff.power_state_code,
						cur_ff.halt_arm};
				end
				clk_sleep_pkg::ADDR_SLEEP_STATUS: begin
					nxt_s.rdata = {3'h0, cur_ff.mode, cur_ff.st};
				end
				default: begin
					nxt_s.rdata = 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset clears the sleep machine, so execution restarts cleanly.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_ff <= '0;
			cur_ff.st <= clk_sleep_pkg::ST_RUN;
		end else begin
			cur_ff <= nxt_s;
		end
	end

	// ----------------------------------------------------------------
	// Clock gating
	// ----------------------------------------------------------------
	clk_sleep_pkg::clk_gate_t gate;

	always_comb begin
		logic asleep;
		asleep = (cur_ff.st != clk_sleep_pkg::ST_RUN);
		gate = '{
			clk_cpu_en: 1'b1,
			clk_io_en: 1'b1,
			clk_adc_en: 1'b1,
			clk_async_en: 1'b1,
			osc_run: 1'b1
		};
		if (asleep) begin
			gate.clk_cpu_en = 1'b0;
			unique case (cur_ff.mode)
				clk_sleep_pkg::MODE_ADC_QUIET: begin
					gate.clk_io_en = 1'b0;
				end
				clk_sleep_pkg::MODE_POWER_DOWN: begin
					gate.clk_io_en = 1'b0;
					gate.clk_adc_en = 1'b0;
					gate.clk_async_en = 1'b0;
					gate.osc_run = 1'b0;
				end
				clk_sleep_pkg::MODE_POWER_SAVE: begin
					gate.clk_io_en = 1'b0;
					gate.clk_adc_en = 1'b0;
					gate.osc_run = 1'b0;
				end
				clk_sleep_pkg::MODE_STANDBY: begin
					gate.clk_io_en = 1'b0;
					gate.clk_adc_en = 1'b0;
					gate.clk_async_en = 1'b0;
				end
				default: begin
				end
			endcase
			if (cur_ff.st == clk_sleep_pkg::ST_WAKE) begin
				gate.osc_run = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// The gated clocks only pulse on a divider tick, so every
	// synchronous peripheral slows with the selected ratio.
	logic [2:0] gate_sel;
	logic [2:0] gated;

	assign gate_sel = {gate.clk_adc_en, gate.clk_io_en, gate.clk_cpu_en};

	for (genvar g = 0; g < 3; g++) begin : g_gate
		assign gated[g] = cur_ff.tick && gate_sel[g];
	end

	assign sys_clk_en = cur_ff.tick;
	assign cpu_halt = (cur_ff.st != clk_sleep_pkg::ST_RUN);
	assign clk_cpu_en = gated[0];
	assign clk_io_en = gated[1];
	assign clk_adc_en = gated[2];
	assign clk_async_en = gate.clk_async_en;
	assign osc_run = gate.osc_run;
	assign rdata = cur_ff.rdata;
	assign wake_done = cur_ff.wake_done;

endmodule
`default_nettype wire

// ==== dv/clk_sleep_asserts.sv ====
`default_nettype none
module clk_sleep_asserts (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic sleep_instr,
	input wire logic wake_irq,
	input wire logic osc_ready,
	input wire logic sys_clk_en,
	input wire logic cpu_halt,
	input wire logic clk_cpu_en,
	input wire logic clk_io_en,
	input wire logic clk_adc_en,
	input wire logic osc_run,
	input wire logic wake_done
);
	// ------------------------------------------------------------
	// Shadow of the low power register
	// ------------------------------------------------------------
	logic arm_ff;
	logic [2:0] mode_ff;
	logic ok;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arm_ff <= 1'b0;
			mode_ff <= 3'h0;
		end else if (wr && addr == clk_sleep_pkg::ADDR_LOW_POWER) begin
			arm_ff <= wdata[0];
			mode_ff <= wdata[3:1];
		end
	end
	// Codes 100, 101 and 111 never put the core to sleep.
	assign ok = mode_ff[2] ? (mode_ff == 3'h6) : 1'b1;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_gate_tick: assert property (
		clk_cpu_en || clk_io_en || clk_adc_en |-> sys_clk_en)
		else $error("gated clock enable without divider tick");
	a_armed_halt: assert property (
		sleep_instr && arm_ff && ok && !cpu_halt |=> cpu_halt)
		else $error("armed sleep did not halt");
	a_unarmed_run: assert property (
		sleep_instr && !arm_ff && !cpu_halt |=> !cpu_halt)
		else $error("unarmed sleep halted");
	a_bad_mode: assert property (
		sleep_instr && !ok && !cpu_halt |=> !cpu_halt)
		else $error("reserved mode halted");
	a_pd_stop: assert property (
		$rose(cpu_halt) && mode_ff == 3'h2
		|-> !(clk_cpu_en || clk_io_en || clk_adc_en || osc_run))
		else $error("power-down left a clock running");
	a_idle_cpu: assert property (
		$rose(cpu_halt) && mode_ff == 3'h0 |-> !clk_cpu_en && osc_run)
		else $error("idle gating wrong");
	a_wake_bound: assert property (
		cpu_halt && wake_irq && osc_ready |-> ##[1:8] !cpu_halt)
		else $error("wake took too long");
	a_wake_wait: assert property (
		$fell(cpu_halt) |-> $past(cpu_halt, 4))
		else $error("halt ended too early");
	a_done_pulse: assert property (
		wake_done |=> !wake_done)
		else $error("wake done longer than one cycle");
	c_sleep: cover property ($rose(cpu_halt));
	c_wake: cover property (wake_done);
	c_standby: cover property ($rose(cpu_halt) && mode_ff == 3'h6);
endmodule
bind clock_prescaler_sleep_ctrl clk_sleep_asserts u_chk (.clk, .arst_n,
	.addr, .wdata, .wr, .sleep_instr, .wake_irq, .osc_ready, .sys_clk_en,
	.cpu_halt, .clk_cpu_en, .clk_io_en, .clk_adc_en, .osc_run, .wake_done);
`default_nettype wire

// ==== dv/clock_prescaler_sleep_ctrl_tb.sv ====
`default_nettype none
module clock_prescaler_sleep_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] P = clk_sleep_pkg::ADDR_PRESCALE;
	localparam logic [3:0] L = clk_sleep_pkg::ADDR_LOW_POWER;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic fuse = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slp = 1'b0;
	logic irq = 1'b0;
	logic osc = 1'b1;
	logic [7:0] rdata;
	logic tick, halt, cpu_en, io_en, adc_en, async_en, osc_run, done;
	int error_cnt = 0;
	int tests_run = 0;
	always #2.5 clk = ~clk;
	clock_prescaler_sleep_ctrl DUT (.clk(clk), .arst_n(arst_n),
		.initial_slow_fuse(fuse), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .sleep_instr(slp), .wake_irq(irq),
		.osc_ready(osc), .sys_clk_en(tick), .cpu_halt(halt),
		.clk_cpu_en(cpu_en), .clk_io_en(io_en), .clk_adc_en(adc_en),
		.clk_async_en(async_en), .osc_run(osc_run), .wake_done(done));
	// ------------------------------------------------------------
	// Bus, timing and report helpers
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("Checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(string n, logic [8:0] e, logic [8:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic rst(logic f);
		fuse <= f;
		osc <= 1'b1;
		arst_n <= 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
	endtask
	task automatic wreg(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(logic [3:0] a, logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", 9'(e), 9'(rdata));
	endtask
	// Measures one full tick period; a switch may shorten the first one.
	task automatic gap(output int n);
		int i;
		i = 0;
		n = 0;
		while (tick !== 1'b1 && i < 600) begin
			@(posedge clk);
			#1 i++;
		end
		do begin
			@(posedge clk);
			#1 n++;
		end while (tick !== 1'b1 && n < 600);
		if (i >= 600 || n >= 600) begin
			error_cnt++;
			wrap_up();
		end
	endtask
	task automatic snooze();
		@(posedge clk);
		slp <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		#1;
	endtask
	task automatic wake();
		int n;
		logic d;
		@(posedge clk);
		irq <= 1'b1;
		n = 0;
		d = 1'b0;
		while (halt !== 1'b0 && n < 20) begin
			@(posedge clk);
			// The oscillator comes up late, so the halt must wait for it.
			if (n == 2) osc <= 1'b1;
			#1 n++;
			d = d | (done === 1'b1);
		end
		irq <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			wrap_up();
		end
		@(posedge clk);
		#1 d = d | (done === 1'b1);
		chk("wake_cycles", 9'h7, 9'(n));
		chk("wake_done", 9'h1, 9'(d));
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_divs();
		int n;
		for (int c = 0; c <= 9; c++) begin
			wreg(P, 8'h80);
			wreg(P, 8'(c));
			rreg(P, c > 8 ? 8'h08 : 8'(c));
			gap(n);
			gap(n);
			chk("period", 9'(1 << (c > 8 ? 8 : c)), 9'(n));
		end
	endtask
	task automatic t_guard();
		wreg(P, 8'h80);
		wreg(P, 8'h02);
		wreg(P, 8'h05);
		rreg(P, 8'h02);
		wreg(P, 8'h81);
		rreg(P, 8'h02);
		wreg(P, 8'h80);
		rreg(P, 8'h82);
		repeat (4) @(posedge clk);
		rreg(P, 8'h02);
		wreg(P, 8'h05);
		rreg(P, 8'h02);
		wreg(P, 8'h80);
		wreg(P, 8'h80);
		rreg(P, 8'h82);
		rreg(P, 8'h02);
	endtask
	task automatic t_sleep();
		logic [2:0] m;
		logic v;
		logic s;
		wreg(L, 8'h00);
		snooze();
		chk("cpu_halt", 9'h0, 9'(halt));
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			v = (i < 4) || (i == 6);
			s = v && (m == 3'h2 || m == 3'h6);
			wreg(L, {4'h0, m, 1'b1});
			snooze();
			chk("cpu_halt", 9'(v), 9'(halt));
			chk("clk_async_en", 9'(!s), 9'(async_en));
			if (s) chk("osc_run", 9'(m[2]), 9'(osc_run));
			if (v) begin
				osc <= 1'b0;
				wake();
			end
		end
		rreg(L, 8'h0F);
	endtask
	task automatic t_rst_sleep();
		wreg(L, 8'h05);
		snooze();
		chk("cpu_halt", 9'h1, 9'(halt));
		rst(1'b0);
		chk("cpu_halt", 9'h0, 9'(halt));
		rreg(P, 8'h00);
		rreg(L, 8'h00);
	endtask
	initial begin
		int n;
		rst(1'b1);
		rreg(P, {4'h0, clk_sleep_pkg::CODE_SLOW});
		gap(n);
		gap(n);
		chk("period", 9'h8, 9'(n));
		rreg(4'hF, 8'h00);
		t_divs();
		t_guard();
		t_sleep();
		t_rst_sleep();
		wrap_up();
	end
endmodule
`default_nettype wire
